// file: pkg/dcp_pkg.sv
// Package: register map, field layout and shared types of the channel priority control block
package dcp_pkg;

  // ----------------------------------------------------------------
  // Bus geometry
  // ----------------------------------------------------------------
  localparam int DCP_DATA_W = 32;
  localparam int DCP_BE_W = 4;
  localparam int DCP_ADDR_W = 8;
  localparam int DCP_MAX_CH = 32;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] DCP_OFS_PRIO_SET = 8'h00;
  localparam logic [7:0] DCP_OFS_PRIO_CLR = 8'h04;
  localparam logic [7:0] DCP_OFS_BUS_ERR = 8'h08;
  localparam logic [7:0] DCP_OFS_IRQ_STATUS = 8'h0C;
  localparam logic [7:0] DCP_OFS_IRQ_MASK = 8'h10;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int DCP_BUS_ERR_BIT = 0;
  localparam int DCP_IRQ_W = 2;
  localparam int DCP_IRQ_BUS_ERR_BIT = 0;
  localparam int DCP_IRQ_UNMAPPED_BIT = 1;
  localparam logic [31:0] DCP_PRIO_RST = 32'h0000_0000;
  localparam logic [31:0] DCP_ZERO_WORD = 32'h0000_0000;
  localparam logic [1:0] DCP_IRQ_RST = 2'h0;
  localparam logic [4:0] DCP_CHAN_RST = 5'h00;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic {
    DCP_BUS_IDLE,
    DCP_BUS_ACK
  } dcp_bus_state_t;

  typedef struct packed {
    logic write;
    logic [DCP_ADDR_W-1:0] address;
    logic [DCP_DATA_W-1:0] writedata;
    logic [DCP_BE_W-1:0] byteenable;
  } dcp_bus_req_t;

  typedef struct packed {
    logic valid;
    logic [4:0] chan;
  } dcp_grant_t;

endpackage

// file: src/dcp_prio_arbiter.sv
// Arbiter choosing one requesting DMA channel from request and priority vectors
`timescale 1ns/1ps
`default_nettype none

module dcp_prio_arbiter #(
  parameter int NUM_CH = 32
) (
  input wire logic [NUM_CH-1:0] chanReq,
  input wire logic [NUM_CH-1:0] chanHigh,
  output dcp_pkg::dcp_grant_t grant
);

  // ----------------------------------------------------------------
  // Elaboration check
  // ----------------------------------------------------------------
  if (NUM_CH < 1 || NUM_CH > dcp_pkg::DCP_MAX_CH) begin : gBadCh
    $error("NUM_CH out of range");
  end

  // ----------------------------------------------------------------
  // Two-level fixed priority
  // ----------------------------------------------------------------
  logic [NUM_CH-1:0] highReq;
  logic [NUM_CH-1:0] pickVec;

  assign highReq = chanReq & chanHigh;
  // High-priority requesters hide normal ones entirely
  assign pickVec = (|highReq) ? highReq : chanReq;

  always_comb begin
    grant.valid = 1'b0;
    grant.chan = dcp_pkg::DCP_CHAN_RST;
    // Scan downward so the lowest number wins the tie
    for (int i = NUM_CH - 1; i >= 0; i--) begin
      if (pickVec[i]) begin
        grant.valid = 1'b1;
        grant.chan = 5'(i);
      end
    end
  end

endmodule

`default_nettype wire

// file: src/dcp_prio_ctrl.sv
// Top: channel priority registers, bus error flag, interrupt logic and arbiter hookup
//
// Summary of operation
// - Writing one to a priority-set bit makes that channel high priority.
// - Zeros written to the priority-set register leave priorities unchanged.
// - Reading priority-set returns each channel's priority, one high, zero normal.
// - Bit n of both priority registers maps to channel n, channels 0 to 31.
// - Writing one to a priority-clear bit returns that channel to normal priority.
// - Zeros written to the priority-clear register have no effect.
// - Bus-error bit0 shows pending error, write one clears, upper bits read zero.
//
// The Avalon-MM register port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

module dcp_prio_ctrl #(
  parameter int NUM_CH = 32
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic clkEn,
  // Avalon-MM slave
  input wire logic [dcp_pkg::DCP_ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [dcp_pkg::DCP_DATA_W-1:0] writedata,
  input wire logic [dcp_pkg::DCP_BE_W-1:0] byteenable,
  output logic [dcp_pkg::DCP_DATA_W-1:0] readdata,
  output logic waitrequest,
  // Channel side
  input wire logic [NUM_CH-1:0] chanReq,
  input wire logic busErrEvent,
  output logic [NUM_CH-1:0] chanHighPrio,
  output logic grantValid,
  output logic [4:0] grantChan,
  output logic irq
);

  // ----------------------------------------------------------------
  // Elaboration check
  // ----------------------------------------------------------------
  if (NUM_CH < 1 || NUM_CH > dcp_pkg::DCP_MAX_CH) begin : gBadCh
    $error("NUM_CH must lie between 1 and 32");
  end

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  dcp_pkg::dcp_bus_state_t busState;
  dcp_pkg::dcp_bus_req_t busReq;
  dcp_pkg::dcp_grant_t arbGrant;
  logic [dcp_pkg::DCP_DATA_W-1:0] wrMask;
  logic [dcp_pkg::DCP_DATA_W-1:0] wrBits;
  logic [dcp_pkg::DCP_DATA_W-1:0] next_readdata;
  logic [dcp_pkg::DCP_DATA_W-1:0] prioWord;
  logic [NUM_CH-1:0] prioSetBits;
  logic [NUM_CH-1:0] prioClrBits;
  logic busErrPending;
  logic [dcp_pkg::DCP_IRQ_W-1:0] irqStatus;
  logic [dcp_pkg::DCP_IRQ_W-1:0] irqMask;
  logic [dcp_pkg::DCP_IRQ_W-1:0] irqEvents;
  logic [dcp_pkg::DCP_IRQ_W-1:0] irqClr;
  logic [dcp_pkg::DCP_IRQ_W-1:0] next_irqStatus;
  logic newReq;
  logic doWrite;
  logic hitPrioSet;
  logic hitPrioClr;
  logic hitBusErr;
  logic hitIrqStatus;
  logic hitIrqMask;
  logic hitAny;
  logic reqHit;
  logic busErrClr;

  // ----------------------------------------------------------------
  // Bus request capture and handshake
  // ----------------------------------------------------------------
  // A request is taken in idle and answered one edge later. The write
  // lands at the very edge where the master sees waitrequest low, so a
  // held request is never applied twice.
  assign newReq = (busState == dcp_pkg::DCP_BUS_IDLE) && (read || write);
  assign doWrite = (busState == dcp_pkg::DCP_BUS_ACK) && busReq.write;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      busState <= dcp_pkg::DCP_BUS_IDLE;
      waitrequest <= 1'b1;
    end else if (clkEn) begin
      case (busState)
        dcp_pkg::DCP_BUS_IDLE: begin
          if (read || write) begin
            busState <= dcp_pkg::DCP_BUS_ACK;
            waitrequest <= 1'b0;
          end
        end
        dcp_pkg::DCP_BUS_ACK: begin
          busState <= dcp_pkg::DCP_BUS_IDLE;
          waitrequest <= 1'b1;
        end
        default: begin
          busState <= dcp_pkg::DCP_BUS_IDLE;
          waitrequest <= 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      busReq <= '0;
    end else if (clkEn && newReq) begin
      busReq.write <= write;
      busReq.address <= address;
      busReq.writedata <= writedata;
      busReq.byteenable <= byteenable;
    end
  end

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  assign hitPrioSet = (busReq.address == dcp_pkg::DCP_OFS_PRIO_SET);
  assign hitPrioClr = (busReq.address == dcp_pkg::DCP_OFS_PRIO_CLR);
  assign hitBusErr = (busReq.address == dcp_pkg::DCP_OFS_BUS_ERR);
  assign hitIrqStatus = (busReq.address == dcp_pkg::DCP_OFS_IRQ_STATUS);
  assign hitIrqMask = (busReq.address == dcp_pkg::DCP_OFS_IRQ_MASK);
  assign hitAny = hitPrioSet | hitPrioClr | hitBusErr | hitIrqStatus | hitIrqMask;

  // Byte lanes that are not enabled write nothing
  for (genvar b = 0; b < dcp_pkg::DCP_BE_W; b++) begin : gLane
    assign wrMask[8*b +: 8] = {8{busReq.byteenable[b]}};
  end
  assign wrBits = busReq.writedata & wrMask;

  // ----------------------------------------------------------------
  // Channel priority state
  // ----------------------------------------------------------------
  // Only ones act; zero bits select nothing
  assign prioSetBits = (doWrite && hitPrioSet) ? wrBits[NUM_CH-1:0] : '0;
  assign prioClrBits = (doWrite && hitPrioClr) ? wrBits[NUM_CH-1:0] : '0;

  // Bit n steers channel n only
  for (genvar c = 0; c < NUM_CH; c++) begin : gChan
    always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
        chanHighPrio[c] <= dcp_pkg::DCP_PRIO_RST[c];
      end else if (clkEn) begin
        if (prioSetBits[c]) begin
          chanHighPrio[c] <= 1'b1;
        end else if (prioClrBits[c]) begin
          chanHighPrio[c] <= 1'b0;
        end
      end
    end
  end

  // Channels NUM_CH and above read as normal priority
  always_comb begin
    prioWord = dcp_pkg::DCP_ZERO_WORD;
    prioWord[NUM_CH-1:0] = chanHighPrio;
  end

  // ----------------------------------------------------------------
  // Bus error flag
  // ----------------------------------------------------------------
  assign busErrClr = doWrite && hitBusErr && wrBits[dcp_pkg::DCP_BUS_ERR_BIT];

  // A new error in the clearing cycle keeps the flag set
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      busErrPending <= 1'b0;
    end else if (clkEn) begin
      if (busErrEvent) begin
        busErrPending <= 1'b1;
      end else if (busErrClr) begin
        busErrPending <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Interrupt status, mask and output
  // ----------------------------------------------------------------
  assign reqHit = doWrite || ((busState == dcp_pkg::DCP_BUS_ACK) && !busReq.write);
  always_comb begin
    irqEvents = '0;
    irqEvents[dcp_pkg::DCP_IRQ_BUS_ERR_BIT] = busErrEvent;
    irqEvents[dcp_pkg::DCP_IRQ_UNMAPPED_BIT] = reqHit && !hitAny;
  end

  assign irqClr = (doWrite && hitIrqStatus) ? wrBits[dcp_pkg::DCP_IRQ_W-1:0] : '0;
  // Set wins over clear so an event in the clearing cycle is kept
  assign next_irqStatus = (irqStatus & ~irqClr) | irqEvents;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      irqStatus <= dcp_pkg::DCP_IRQ_RST;
    end else if (clkEn) begin
      irqStatus <= next_irqStatus;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      irqMask <= dcp_pkg::DCP_IRQ_RST;
    end else if (clkEn && doWrite && hitIrqMask) begin
      irqMask <= (irqMask & ~wrMask[dcp_pkg::DCP_IRQ_W-1:0])
                 | wrBits[dcp_pkg::DCP_IRQ_W-1:0];
    end
  end

  // Output is taken from the next status, so it changes at the same edge as the status and stays a clean flop
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else if (clkEn) begin
      irq <= |(next_irqStatus & irqMask);
    end
  end

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  // Decode on the live address: data is latched in the same edge as the
  // request, then held for the answer edge.
  always_comb begin
    next_readdata = dcp_pkg::DCP_ZERO_WORD;
    case (address)
      dcp_pkg::DCP_OFS_PRIO_SET: begin
        next_readdata = prioWord;
      end
      dcp_pkg::DCP_OFS_PRIO_CLR: begin
        // Contents are undefined to software; zero is returned
        next_readdata = dcp_pkg::DCP_ZERO_WORD;
      end
      dcp_pkg::DCP_OFS_BUS_ERR: begin
        next_readdata[dcp_pkg::DCP_BUS_ERR_BIT] = busErrPending;
      end
      dcp_pkg::DCP_OFS_IRQ_STATUS: begin
        next_readdata[dcp_pkg::DCP_IRQ_W-1:0] = irqStatus;
      end
      dcp_pkg::DCP_OFS_IRQ_MASK: begin
        next_readdata[dcp_pkg::DCP_IRQ_W-1:0] = irqMask;
      end
      default: begin
        next_readdata = dcp_pkg::DCP_ZERO_WORD;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      readdata <= dcp_pkg::DCP_ZERO_WORD;
    end else if (clkEn && newReq && read) begin
      readdata <= next_readdata;
    end
  end

  // ----------------------------------------------------------------
  // Arbitration
  // ----------------------------------------------------------------
  dcp_prio_arbiter #(
    .NUM_CH(NUM_CH)
  ) uArb (
    .chanReq(chanReq),
    .chanHigh(chanHighPrio),
    .grant(arbGrant)
  );

  // Grant registered for a clean output; it lags requests by one edge
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      grantValid <= 1'b0;
      grantChan <= dcp_pkg::DCP_CHAN_RST;
    end else if (clkEn) begin
      grantValid <= arbGrant.valid;
      grantChan <= arbGrant.chan;
    end
  end

endmodule

`default_nettype wire

// file: tb/dcp_prio_ctrl_asserts.sv
// Checker: port properties of the channel priority block
`timescale 1ns/1ps
`default_nettype none
module dcp_prio_ctrl_asserts #(
  parameter int NUM_CH = 32
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic clkEn,
  input wire logic [dcp_pkg::DCP_ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [dcp_pkg::DCP_DATA_W-1:0] writedata,
  input wire logic [dcp_pkg::DCP_BE_W-1:0] byteenable,
  input wire logic [dcp_pkg::DCP_DATA_W-1:0] readdata,
  input wire logic waitrequest,
  input wire logic [NUM_CH-1:0] chanReq,
  input wire logic busErrEvent,
  input wire logic [NUM_CH-1:0] chanHighPrio,
  input wire logic grantValid,
  input wire logic [4:0] grantChan,
  input wire logic irq
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // ----
  // Helpers
  // ----
  logic acc;
  logic wrSet;
  logic wrClr;
  logic [NUM_CH-1:0] reqQ;
  logic [NUM_CH-1:0] hiQ;
  logic [NUM_CH-1:0] pend;
  assign acc = !waitrequest && clkEn;
  assign wrSet = acc && write && address == dcp_pkg::DCP_OFS_PRIO_SET && byteenable == 4'hF;
  assign wrClr = acc && write && address == dcp_pkg::DCP_OFS_PRIO_CLR && byteenable == 4'hF;
  // Grant answers the request and priority seen one edge earlier
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      reqQ <= '0;
      hiQ <= '0;
    end else if (clkEn) begin
      reqQ <= chanReq;
      hiQ <= chanHighPrio;
    end
  end
  assign pend = ((reqQ & hiQ) != '0) ? (reqQ & hiQ) : reqQ;
  // ----
  // Properties
  // ----
  AST_PRIO_SET: assert property (
    wrSet |=> chanHighPrio == ($past(chanHighPrio) | $past(writedata)))
    else $error("priority set write wrong");
  AST_PRIO_CLR: assert property (
    wrClr |=> chanHighPrio == ($past(chanHighPrio) & ~$past(writedata)))
    else $error("priority clear write wrong");
  AST_PRIO_HOLD: assert property (!(acc && write) |=> $stable(chanHighPrio))
    else $error("priority changed without write");
  AST_RD_SET: assert property (
    acc && read && address == dcp_pkg::DCP_OFS_PRIO_SET |-> readdata == chanHighPrio)
    else $error("priority read mismatch");
  AST_ERR_UPPER: assert property (
    acc && read && address == dcp_pkg::DCP_OFS_BUS_ERR |-> readdata[31:1] == '0)
    else $error("bus error upper bits not zero");
  AST_WAIT_ONE: assert property (acc |=> waitrequest)
    else $error("waitrequest low too long");
  AST_WAIT_TAKE: assert property ((read || write) && waitrequest && clkEn |=> !waitrequest)
    else $error("request not answered in one cycle");
  AST_GRANT_VALID: assert property (grantValid == (reqQ != '0))
    else $error("grant valid wrong");
  AST_GRANT_PICK: assert property (
    grantValid |-> pend[grantChan] && (pend << (NUM_CH - grantChan)) == '0)
    else $error("grant channel wrong");
  cover property (wrSet);
  cover property (grantValid && chanHighPrio[grantChan]);
  cover property (irq);
endmodule
bind dcp_prio_ctrl dcp_prio_ctrl_asserts #(.NUM_CH(NUM_CH)) dcp_prio_ctrl_asserts_inst (
  .clk_sys(clk_sys), .rst_n(rst_n), .clkEn(clkEn), .address(address), .read(read),
  .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
  .waitrequest(waitrequest), .chanReq(chanReq), .busErrEvent(busErrEvent),
  .chanHighPrio(chanHighPrio), .grantValid(grantValid), .grantChan(grantChan), .irq(irq));
`default_nettype wire

// file: tb/dcp_prio_ctrl_tb_top.sv
// Testbench: register, interrupt and arbitration checks
`timescale 1ns/1ps
`default_nettype none
module dcp_prio_ctrl_tb_top;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [7:0] address = 8'h00;
  logic [31:0] writedata = 32'h0;
  logic [3:0] byteenable = 4'hF;
  logic [31:0] chanReq = 32'h0;
  logic busErrEvent = 1'b0;
  logic clkEn = 1'b1;
  logic [31:0] readdata, chanHighPrio, q;
  logic waitrequest, grantValid, irq;
  logic [4:0] grantChan;
  logic [31:0] reqs [4] = '{32'h28, 32'h8000_0028, 32'h8000_0128, 32'h0};
  logic [5:0] exps [4] = '{6'h23, 6'h3F, 6'h28, 6'h00};
  int fails = 0;
  int nChecks = 0;
  int cyc = 0;
  always #2 clk_sys = ~clk_sys;
  dcp_prio_ctrl dcp_prio_ctrl_inst (.clk_sys(clk_sys), .rst_n(rst_n), .clkEn(clkEn),
    .address(address), .read(read), .write(write), .writedata(writedata),
    .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
    .chanReq(chanReq), .busErrEvent(busErrEvent), .chanHighPrio(chanHighPrio),
    .grantValid(grantValid), .grantChan(grantChan), .irq(irq));
  // ----
  // Tasks
  // ----
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    nChecks++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
    input logic [3:0] be);
    @(posedge clk_sys);
    write <= wr;
    read <= !wr;
    address <= a;
    writedata <= d;
    byteenable <= be;
    do @(posedge clk_sys); while (waitrequest !== 1'b0);
    q = readdata;
    write <= 1'b0;
    read <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d, 4'hF);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0, 4'hF);
    chk(q, e);
  endtask
  task automatic wait2;
    repeat (2) @(posedge clk_sys);
  endtask
  task automatic tally_and_finish;
    $display("checks=%0d mismatches=%0d", nChecks, fails);
    if (fails == 0 && nChecks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // Whole run needs well under two hundred cycles
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 3000) begin
      fails++;
      tally_and_finish;
    end
  end
  // ----
  // Tests
  // ----
  initial begin
    repeat (16) @(posedge clk_sys);
    rst_n <= 1'b1;
    rd(dcp_pkg::DCP_OFS_PRIO_SET, 32'h0);
    wr(dcp_pkg::DCP_OFS_PRIO_SET, 32'h8000_0001);
    rd(dcp_pkg::DCP_OFS_PRIO_SET, 32'h8000_0001);
    chk(chanHighPrio, 32'h8000_0001);
    wr(dcp_pkg::DCP_OFS_PRIO_SET, 32'h0);
    wr(dcp_pkg::DCP_OFS_PRIO_SET, 32'h100);
    rd(dcp_pkg::DCP_OFS_PRIO_SET, 32'h8000_0101);
    wr(dcp_pkg::DCP_OFS_PRIO_CLR, 32'h1);
    wr(dcp_pkg::DCP_OFS_PRIO_CLR, 32'h0);
    rd(dcp_pkg::DCP_OFS_PRIO_SET, 32'h8000_0100);
    $display("test priority registers done");
    for (int i = 0; i < 4; i++) begin
      chanReq <= reqs[i];
      wait2;
      chk({26'h0, grantValid, grantValid ? grantChan : 5'h0}, {26'h0, exps[i]});
    end
    // Only lane 1 enabled: set must not reach other bytes
    bus(1'b1, dcp_pkg::DCP_OFS_PRIO_SET, 32'hFFFF_FFFF, 4'h2);
    rd(dcp_pkg::DCP_OFS_PRIO_SET, 32'h8000_FF00);
    $display("test arbitration and lanes done");
    // Clock enable low: an error pulse in a frozen cycle is lost
    clkEn <= 1'b0;
    busErrEvent <= 1'b1;
    @(posedge clk_sys);
    clkEn <= 1'b1;
    busErrEvent <= 1'b0;
    rd(dcp_pkg::DCP_OFS_BUS_ERR, 32'h0);
    busErrEvent <= 1'b1;
    @(posedge clk_sys);
    busErrEvent <= 1'b0;
    rd(dcp_pkg::DCP_OFS_BUS_ERR, 32'h1);
    wr(dcp_pkg::DCP_OFS_BUS_ERR, 32'h0);
    rd(dcp_pkg::DCP_OFS_BUS_ERR, 32'h1);
    wr(dcp_pkg::DCP_OFS_BUS_ERR, 32'h1);
    rd(dcp_pkg::DCP_OFS_BUS_ERR, 32'h0);
    rd(8'h40, 32'h0);
    rd(dcp_pkg::DCP_OFS_IRQ_STATUS, 32'h3);
    chk(irq, 32'h0);
    wr(dcp_pkg::DCP_OFS_IRQ_MASK, 32'h2);
    wait2;
    chk(irq, 32'h1);
    wr(dcp_pkg::DCP_OFS_IRQ_STATUS, 32'h2);
    wait2;
    chk(irq, 32'h0);
    rd(dcp_pkg::DCP_OFS_IRQ_STATUS, 32'h1);
    wr(dcp_pkg::DCP_OFS_IRQ_MASK, 32'h3);
    rd(dcp_pkg::DCP_OFS_IRQ_MASK, 32'h3);
    chk(irq, 32'h1);
    wr(dcp_pkg::DCP_OFS_IRQ_STATUS, 32'h1);
    wait2;
    chk(irq, 32'h0);
    $display("test bus error and interrupt done");
    tally_and_finish;
  end
endmodule
`default_nettype wire
